// ==== design/lpc_regs.sv ====
// Laser power control register bank with motion registers and laser drive outputs.
// Assumes the controller programs the laser pair after every reset and a frame
// engine supplies per-frame displacement at the base resolution.
`timescale 1ns/1ps

// Behaviour
// - normal mode pulses the laser drive
// - calibration mode drives laser continuously
// - range field bits 7:6, low is 01
// - complement register bits 7:6 invert range
// - calibration field bits 3:1 forces full duty
// - current register, complement must invert it
// - device drives current per range and setting
// - displacement from frames readable over port
// - motion registers are twelve bits wide
// - selectable resolution 400 to 2000 cpi
// - motion output low while motion pending
// - supply enable goes high on laser fault
module lpc_regs
#(
  parameter int PULSE_ON_CYC     = lpc_pkg::PULSE_ON_CYC,     // Pulse on time in cycles.
  parameter int PULSE_PERIOD_CYC = lpc_pkg::PULSE_PERIOD_CYC  // Pulse period in cycles.
)
(
  input  wire logic                        mclk,                  // System clock.
  input  wire logic                        rst_b,                 // Async reset, active low.
  input  wire logic                        ce,                    // Clock enable.
  input  wire logic                        chip_select_n,         // Serial select, active low.
  input  wire logic                        sclk,                  // Serial clock.
  input  wire logic                        mosi,                  // Serial data in.
  output logic                             miso,                  // Serial data out.
  output logic                             miso_oe,               // Serial data out enable.
  input  wire logic                        laser_pin_fault,       // Fault sensed at drive pin.
  input  wire logic                        frame_valid,           // Frame displacement valid.
  input  wire logic [lpc_pkg::FRAME_W-1:0] frame_dx,              // Frame X step, signed.
  input  wire logic [lpc_pkg::FRAME_W-1:0] frame_dy,              // Frame Y step, signed.
  output logic                             laser_supply_enable_n, // Supply switch, low is on.
  output logic                             laser_drive_on_q,      // Drive current source on.
  output logic                      [1:0]  laser_range_q,         // Current range select.
  output logic                      [7:0]  laser_current_q,       // Current setting.
  output logic                             motion_n_q             // Motion pending, active low.
);

  logic [7:0]        ctrl_pri_q;
  logic [7:0]        ctrl_cmp_q;
  logic [7:0]        cur_set_q;
  logic [7:0]        cur_cmp_q;
  logic [2:0]        res_q;
  logic              fault_q;
  logic              supply_n_q;
  lpc_pkg::lpc_mot_t dx_q;
  lpc_pkg::lpc_mot_t dy_q;
  logic [15:0]       pulse_cnt_q;
  logic [6:0]        addr;
  logic              wr;
  logic [7:0]        wr_data;
  logic              rd;
  logic [7:0]        rd_data;
  logic              pair_ok;
  logic              cal_on;
  logic              pulse_phase;
  logic              clr_motion;
  logic signed [11:0] inc_x;
  logic signed [11:0] inc_y;
  logic [3:0]        mult;

  assign laser_supply_enable_n = supply_n_q;

  // Serial port front end.
  lpc_serial u_serial
  (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .ce            (ce),
    .chip_select_n (chip_select_n),
    .sclk          (sclk),
    .mosi          (mosi),
    .rd_data       (rd_data),
    .addr_q        (addr),
    .wr_q          (wr),
    .wr_data_q     (wr_data),
    .rd_q          (rd),
    .miso_q        (miso),
    .miso_oe_q     (miso_oe)
  );

  // Saturating add keeps a long move from wrapping to the opposite direction.
  function automatic lpc_pkg::lpc_mot_t lpc_sat(input lpc_pkg::lpc_mot_t acc,
                                                input logic [11:0] inc);
    logic [12:0] s;
    s = {acc[11], acc} + {inc[11], inc};
    if (s[12] != s[11])
      lpc_sat = s[12] ? lpc_pkg::MOT_NEG_MAX : lpc_pkg::MOT_POS_MAX;
    else
      lpc_sat = s[11:0];
  endfunction : lpc_sat

  // laser register writes
  // Laser pair registers are plain read-write bytes reached by address.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      ctrl_pri_q <= lpc_pkg::CTRL_PRI_RST;
      ctrl_cmp_q <= lpc_pkg::CTRL_CMP_RST;
      cur_set_q  <= lpc_pkg::CUR_SET_RST;
      cur_cmp_q  <= lpc_pkg::CUR_CMP_RST;
      res_q      <= lpc_pkg::RES_RST;
    end
    else if (ce && wr)
    begin
      unique case (addr)
        lpc_pkg::ADDR_CTRL_PRI: ctrl_pri_q <= wr_data;
        lpc_pkg::ADDR_CTRL_CMP: ctrl_cmp_q <= wr_data;
        lpc_pkg::ADDR_CUR_SET:  cur_set_q  <= wr_data;
        lpc_pkg::ADDR_CUR_CMP:  cur_cmp_q  <= wr_data;
        lpc_pkg::ADDR_RES:
          if (wr_data[2:0] <= lpc_pkg::RES_MAX)
            res_q <= wr_data[2:0];
        default: ;
      endcase
    end

  // complement pair check
  // A half-written pair reads as inconsistent, so the drive is held off until both match.
  assign pair_ok = (ctrl_cmp_q[lpc_pkg::RANGE_MSB:lpc_pkg::RANGE_LSB]
                    == ~ctrl_pri_q[lpc_pkg::RANGE_MSB:lpc_pkg::RANGE_LSB])
                   && (cur_cmp_q == ~cur_set_q);

  assign cal_on = ctrl_pri_q[lpc_pkg::CAL_MSB:lpc_pkg::CAL_LSB] == lpc_pkg::CAL_ON;

  // Register read mux; unmapped addresses read as zero.
  always_comb
  begin
    rd_data = 8'h00;
    unique case (addr)
      lpc_pkg::ADDR_CTRL_PRI: rd_data = ctrl_pri_q;
      lpc_pkg::ADDR_CTRL_CMP: rd_data = ctrl_cmp_q;
      lpc_pkg::ADDR_CUR_SET:  rd_data = cur_set_q;
      lpc_pkg::ADDR_CUR_CMP:  rd_data = cur_cmp_q;
      lpc_pkg::ADDR_RES:      rd_data = {5'h00, res_q};
      lpc_pkg::ADDR_DX_LO:    rd_data = dx_q[7:0];
      lpc_pkg::ADDR_DY_LO:    rd_data = dy_q[7:0];
      lpc_pkg::ADDR_XY_HI:    rd_data = {dy_q[11:8], dx_q[11:8]};
      lpc_pkg::ADDR_STATUS:
      begin
        rd_data[lpc_pkg::ST_MOTION] = ~motion_n_q;
        rd_data[lpc_pkg::ST_CAL]    = cal_on;
        rd_data[lpc_pkg::ST_FAULT]  = fault_q;
      end
      default: rd_data = 8'h00;
    endcase
  end

  // fault latch
  // A fault stays latched until reset; re-enabling by software would defeat eye safety.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      fault_q    <= 1'b0;
      supply_n_q <= 1'b0;
    end
    else if (ce)
    begin
      if (laser_pin_fault)
        fault_q <= 1'b1;
      supply_n_q <= fault_q | laser_pin_fault;
    end

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      pulse_cnt_q <= 16'h0000;
    else if (ce)
    begin
      if (pulse_cnt_q >= 16'(PULSE_PERIOD_CYC - 1))
        pulse_cnt_q <= 16'h0000;
      else
        pulse_cnt_q <= pulse_cnt_q + 16'h0001;
    end

  assign pulse_phase = pulse_cnt_q < 16'(PULSE_ON_CYC);

  // laser drive outputs
  // Range always follows the primary register; current follows only while the pairs agree and no fault is latched.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      laser_drive_on_q <= 1'b0;
      laser_range_q    <= 2'h0;
      laser_current_q  <= 8'h00;
    end
    else if (ce)
    begin
      laser_range_q    <= ctrl_pri_q[lpc_pkg::RANGE_MSB:lpc_pkg::RANGE_LSB];
      laser_current_q  <= (pair_ok && !fault_q) ? cur_set_q : 8'h00;
      laser_drive_on_q <= pair_ok && !fault_q && !laser_pin_fault && (cal_on || pulse_phase);
    end

  // resolution scaling
  // Frame steps arrive at 400 cpi; the multiplier gives 400 to 2000 cpi.
  assign mult  = {1'b0, res_q} + 4'h1;
  assign inc_x = 12'($signed(frame_dx) * $signed({1'b0, mult}));
  assign inc_y = 12'($signed(frame_dy) * $signed({1'b0, mult}));
  assign clr_motion = rd && (addr == lpc_pkg::ADDR_XY_HI);

  // twelve bit accumulators
  // Reading the high byte clears; a frame in the same cycle is kept, not lost.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      dx_q <= lpc_pkg::MOT_ZERO;
      dy_q <= lpc_pkg::MOT_ZERO;
    end
    else if (ce)
    begin
      if (frame_valid)
      begin
        dx_q <= lpc_sat(clr_motion ? lpc_pkg::MOT_ZERO : dx_q, inc_x);
        dy_q <= lpc_sat(clr_motion ? lpc_pkg::MOT_ZERO : dy_q, inc_y);
      end
      else if (clr_motion)
      begin
        dx_q <= lpc_pkg::MOT_ZERO;
        dy_q <= lpc_pkg::MOT_ZERO;
      end
    end

  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      motion_n_q <= 1'b1;
    else if (ce)
      motion_n_q <= (dx_q == lpc_pkg::MOT_ZERO) && (dy_q == lpc_pkg::MOT_ZERO);

  // Helper: calibration decode as it stood when the current drive value was decided.
  // A run begun in calibration mode is not counted, so leaving that mode cannot trip the check.
  logic        cal_d1_q;
  logic [15:0] on_run_q;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      cal_d1_q <= 1'b0;
    else if (ce)
      cal_d1_q <= cal_on;

  // Helper: length of the current run of drive-on cycles decided in normal mode.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      on_run_q <= 16'h0000;
    else if (ce)
      on_run_q <= (laser_drive_on_q && !cal_d1_q) ? on_run_q + 16'h0001 : 16'h0000;

  chk_pulse_run_bounded : assert property (@(posedge mclk) disable iff (!rst_b)
    !cal_on |-> on_run_q <= 16'(PULSE_ON_CYC))
    else $error("Laser drive on longer than one pulse in normal mode.");

  chk_cal_continuous : assert property (@(posedge mclk) disable iff (!rst_b)
    (ce && cal_on && pair_ok && !fault_q && !laser_pin_fault) [*2] |=> laser_drive_on_q)
    else $error("Calibration mode did not hold the laser on.");

  chk_range_follows : assert property (@(posedge mclk) disable iff (!rst_b)
    ce |=> laser_range_q == $past(ctrl_pri_q[lpc_pkg::RANGE_MSB:lpc_pkg::RANGE_LSB]))
    else $error("Range output does not follow the range field.");

  chk_pair_gates_drive : assert property (@(posedge mclk) disable iff (!rst_b)
    ce && !pair_ok |=> !laser_drive_on_q && laser_current_q == 8'h00)
    else $error("Laser driven with an inconsistent complement pair.");

  chk_current_follows : assert property (@(posedge mclk) disable iff (!rst_b)
    ce && pair_ok && !fault_q |=> laser_current_q == $past(cur_set_q))
    else $error("Laser current does not follow the setting.");

  chk_fault_cuts_laser : assert property (@(posedge mclk) disable iff (!rst_b)
    ce && fault_q |=> laser_supply_enable_n && !laser_drive_on_q)
    else $error("Laser still powered after a fault.");

  chk_motion_pin : assert property (@(posedge mclk) disable iff (!rst_b)
    ce && (dx_q != lpc_pkg::MOT_ZERO) |=> !motion_n_q)
    else $error("Motion output not asserted with motion pending.");

  chk_write_lands : assert property (@(posedge mclk) disable iff (!rst_b)
    ce && wr && addr == lpc_pkg::ADDR_CUR_SET |=> cur_set_q == $past(wr_data))
    else $error("Current setting write was lost.");

  chk_res_scale : assert property (@(posedge mclk) disable iff (!rst_b)
    ce && frame_valid && !clr_motion && dx_q == lpc_pkg::MOT_ZERO && res_q == 3'h0
    |=> dx_q == {{4{$past(frame_dx[7])}}, $past(frame_dx)})
    else $error("Base resolution step not accumulated exactly.");

  chk_motion_clear : assert property (@(posedge mclk) disable iff (!rst_b)
    ce && clr_motion && !frame_valid |=> dx_q == lpc_pkg::MOT_ZERO && dy_q == lpc_pkg::MOT_ZERO)
    else $error("Reading the high byte did not clear the motion counts.");

endmodule : lpc_regs

// ==== common/lpc_pkg.sv ====
// Constants, register map and types for the laser power control register bank.
// Assumes a single 200 MHz clock domain and the four-wire serial port of the sensor.
package lpc_pkg;

  // Clock period used to turn times into cycle counts.
  localparam int CLK_PERIOD_PS = 5000;

  // Laser register addresses on the serial port.
  localparam logic [6:0] ADDR_CTRL_PRI = 7'h1A;
  localparam logic [6:0] ADDR_CUR_SET  = 7'h1C;
  localparam logic [6:0] ADDR_CUR_CMP  = 7'h1D;
  localparam logic [6:0] ADDR_CTRL_CMP = 7'h1F;
  // Motion and resolution registers.
  localparam logic [6:0] ADDR_STATUS   = 7'h02;
  localparam logic [6:0] ADDR_DX_LO    = 7'h03;
  localparam logic [6:0] ADDR_DY_LO    = 7'h04;
  localparam logic [6:0] ADDR_XY_HI    = 7'h05;
  localparam logic [6:0] ADDR_RES      = 7'h0D;

  // Serial command byte layout: top bit marks a write.
  localparam int WR_FLAG_BIT = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Field positions inside the control pair.
  localparam int RANGE_MSB = 7;
  localparam int RANGE_LSB = 6;
  localparam int CAL_MSB   = 3;
  localparam int CAL_LSB   = 1;
  localparam logic [1:0] RANGE_LOW  = 2'h1;
  localparam logic [1:0] RANGE_HIGH = 2'h2;
  localparam logic [2:0] CAL_ON     = 3'h7;

  // Reset values: a consistent pair with the laser current at its minimum.
  localparam logic [7:0] CTRL_PRI_RST = 8'h40;
  localparam logic [7:0] CTRL_CMP_RST = 8'h80;
  localparam logic [7:0] CUR_SET_RST  = 8'h00;
  localparam logic [7:0] CUR_CMP_RST  = 8'hFF;

  // Resolution select: code 0..4 gives 400..2000 counts per inch.
  localparam logic [2:0] RES_MAX = 3'h4;
  localparam logic [2:0] RES_RST = 3'h1;

  // Motion accumulator layout.
  localparam int MOTION_W = 12;
  localparam int FRAME_W  = 8;
  localparam logic [MOTION_W-1:0] MOT_POS_MAX = 12'h7FF;
  localparam logic [MOTION_W-1:0] MOT_NEG_MAX = 12'h800;
  localparam logic [MOTION_W-1:0] MOT_ZERO    = 12'h000;

  // Status register bit positions.
  localparam int ST_MOTION = 7;
  localparam int ST_CAL    = 1;
  localparam int ST_FAULT  = 0;

  // Normal mode pulse timing: least on time rounds up, period rounds down.
  localparam int PULSE_ON_NS     = 200;
  localparam int PULSE_PERIOD_NS = 1000;
  localparam int PULSE_ON_CYC     = (PULSE_ON_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_PERIOD_CYC = (PULSE_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  typedef logic [MOTION_W-1:0] lpc_mot_t;

  // Serial transfer phase, Gray coded along idle, address, data.
  typedef enum logic [1:0]
  {
    LPC_IDLE = 2'b00,
    LPC_ADDR = 2'b01,
    LPC_DATA = 2'b11
  } lpc_phase_e;

endpackage : lpc_pkg

// ==== design/lpc_serial.sv ====
// Four-wire serial port slave: address byte then data byte, MSB first.
// Assumes chip select, serial clock and data in are synchronous to mclk.
`timescale 1ns/1ps

module lpc_serial
(
  input  wire logic       mclk,          // System clock.
  input  wire logic       rst_b,         // Asynchronous reset, active low.
  input  wire logic       ce,            // Clock enable, freezes state when low.
  input  wire logic       chip_select_n, // Serial select, active low.
  input  wire logic       sclk,          // Serial clock.
  input  wire logic       mosi,          // Serial data in.
  input  wire logic [7:0] rd_data,       // Read data for the latched address.
  output logic      [6:0] addr_q,        // Latched register address.
  output logic            wr_q,          // Write strobe, one cycle.
  output logic      [7:0] wr_data_q,     // Write data.
  output logic            rd_q,          // Read strobe, one cycle.
  output logic            miso_q,        // Serial data out.
  output logic            miso_oe_q      // Data out driven while selected.
);

  logic             sclk_q;
  logic       [2:0] bit_cnt_q;
  logic       [7:0] in_sr_q;
  logic       [7:0] out_sr_q;
  logic             is_wr_q;
  lpc_pkg::lpc_phase_e phase_q;
  logic             rise;
  logic             fall;
  logic       [7:0] byte_in;

  // Edges of the sampled serial clock.
  assign rise    = sclk & ~sclk_q;
  assign fall    = ~sclk & sclk_q;
  assign byte_in = {in_sr_q[6:0], mosi};

  // Input shifter and transfer phase; deselect aborts any partial byte.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      sclk_q    <= 1'b0;
      bit_cnt_q <= 3'h0;
      in_sr_q   <= 8'h00;
      is_wr_q   <= 1'b0;
      addr_q    <= 7'h00;
      wr_q      <= 1'b0;
      wr_data_q <= 8'h00;
      rd_q      <= 1'b0;
      phase_q   <= lpc_pkg::LPC_IDLE;
    end
    else if (ce)
    begin
      sclk_q <= sclk;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      if (chip_select_n)
      begin
        bit_cnt_q <= 3'h0;
        phase_q   <= lpc_pkg::LPC_IDLE;
      end
      else if (rise)
      begin
        in_sr_q   <= byte_in;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        unique case (phase_q)
          lpc_pkg::LPC_IDLE, lpc_pkg::LPC_ADDR:
          begin
            phase_q <= lpc_pkg::LPC_ADDR;
            if (bit_cnt_q == lpc_pkg::LAST_BIT)
            begin
              addr_q  <= byte_in[6:0];
              is_wr_q <= byte_in[lpc_pkg::WR_FLAG_BIT];
              rd_q    <= ~byte_in[lpc_pkg::WR_FLAG_BIT];
              phase_q <= lpc_pkg::LPC_DATA;
            end
          end
          lpc_pkg::LPC_DATA:
            if (bit_cnt_q == lpc_pkg::LAST_BIT)
            begin
              wr_q      <= is_wr_q;
              wr_data_q <= byte_in;
              phase_q   <= lpc_pkg::LPC_ADDR;
            end
        endcase
      end
    end

  // Output shifter; the read byte is captured with the read strobe and sent on falls.
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      out_sr_q  <= 8'h00;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end
    else if (ce)
    begin
      miso_oe_q <= ~chip_select_n;
      if (rd_q)
        out_sr_q <= rd_data;
      else if (fall && !chip_select_n && phase_q == lpc_pkg::LPC_DATA && !is_wr_q)
      begin
        miso_q   <= out_sr_q[7];
        out_sr_q <= {out_sr_q[6:0], 1'b0};
      end
    end

endmodule : lpc_serial

// ==== tb/lpc_host.sv ====
// Model of the controller on the far side of the laser register serial port.
// Assumes idle-low serial clock and a register bank that samples pins on mclk.
`timescale 1ns/1ps

module lpc_host
(
  input  wire logic mclk,          // System clock, shared with the device.
  input  wire logic miso,          // Serial data from the device.
  input  wire logic miso_oe,       // Device drives miso while high.
  output logic      chip_select_n, // Serial select, active low.
  output logic      sclk,          // Serial clock, idle low.
  output logic      mosi           // Serial data to the device.
);
  localparam int HALF = 4; // Serial clock half period, above the three-cycle minimum.

  initial
  begin
    chip_select_n = 1'b1;
    sclk          = 1'b0;
    mosi          = 1'b0;
  end

  // One byte, MSB first; miso is taken at the rising serial clock, where it is settled.
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge mclk);
      sclk <= 1'b0;
      mosi <= tx[i];
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (HALF) @(posedge mclk);
    end
  endtask : xfer_byte

  // select low: one address byte then one data byte inside a select window.
  // read path: the same frame carries displacement reads.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] dummy;
    @(posedge mclk);
    chip_select_n <= 1'b0;
    repeat (2) @(posedge mclk);
    xfer_byte(cmd, dummy);
    xfer_byte(tx, rx);
    @(posedge mclk);
    sclk <= 1'b0;
    repeat (HALF) @(posedge mclk);
    chip_select_n <= 1'b1;
    // A released data line shows no stale bit.
    mosi <= ~mosi;
    repeat (HALF) @(posedge mclk);
  endtask : xfer

  // safe values: writes are only issued as the bench commands.
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] rx;
    xfer({1'b1, addr}, data, rx);
  endtask : wr

  task automatic rd(input logic [6:0] addr, output logic [7:0] data);
    xfer({1'b0, addr}, 8'h00, data);
  endtask : rd

  // restore pair: writes the reset values 40, 80, 00, FF back to the laser pairs after a reset.
  task automatic restore();
    wr(7'h1A, 8'h40);
    wr(7'h1F, 8'h80);
    wr(7'h1C, 8'h00);
    wr(7'h1D, 8'hFF);
  endtask : restore
endmodule : lpc_host

// ==== tb/tb_top.sv ====
// Self-checking bench for the laser power control register bank.
// Assumes the serial controller model drives the port and the bench drives frames and faults.
`timescale 1ns/1ps

module tb_top;
  typedef struct {logic [6:0] a; logic [7:0] d; logic [1:0] rng; logic [7:0] cur;} lpc_row_s;

  logic       mclk;
  logic       rst_b;
  logic       ce;
  logic       cs_n, sclk, mosi, miso, miso_oe, fault, fv, sup_n, drv, mot_n;
  logic [7:0] fdx, fdy, cur, rd_v;
  logic [1:0] rng;
  int         n_errors;
  int         samples_checked;
  int         cnt;

  // Writes one at a time; a half-written pair must keep the current at zero.
  lpc_row_s rows [6] = '{
    '{7'h1C, 8'h05, 2'h1, 8'h00}, '{7'h1D, 8'hFA, 2'h1, 8'h05},
    '{7'h1A, 8'h80, 2'h2, 8'h00}, '{7'h1F, 8'h40, 2'h2, 8'h05},
    '{7'h1C, 8'h00, 2'h2, 8'h00}, '{7'h1D, 8'hFF, 2'h2, 8'h00}};

  lpc_regs #(.PULSE_ON_CYC(4), .PULSE_PERIOD_CYC(10)) dut (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .chip_select_n(cs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .laser_pin_fault(fault), .frame_valid(fv),
    .frame_dx(fdx), .frame_dy(fdy), .laser_supply_enable_n(sup_n), .laser_drive_on_q(drv),
    .laser_range_q(rng), .laser_current_q(cur), .motion_n_q(mot_n));

  lpc_host host (.mclk(mclk), .miso(miso), .miso_oe(miso_oe), .chip_select_n(cs_n),
    .sclk(sclk), .mosi(mosi));

  // Clock at 200 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Counts drive-on cycles over a span; a whole number of pulse periods fixes the result.
  task automatic count_drive(input int n);
    cnt = 0;
    repeat (n) @(posedge mclk) cnt += int'(drv);
  endtask : count_drive

  task automatic frame(input logic [7:0] dx, input logic [7:0] dy);
    @(posedge mclk);
    fv  <= 1'b1;
    fdx <= dx;
    fdy <= dy;
    @(posedge mclk);
    fv  <= 1'b0;
  endtask : frame

  // Watchdog well above the roughly 6500 cycles the sequence needs.
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    end_sim();
  end

  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    fault = 1'b0;
    fv = 1'b0;
    fdx = 8'h00;
    fdy = 8'h00;
    repeat (3) @(posedge mclk);
    check("sup_rst", sup_n, 12'h000);
    check("drv_rst", drv, 12'h000);
    check("mot_rst", mot_n, 12'h001);
    check("oe_rst", miso_oe, 12'h000);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    check("rng_init", rng, 12'h001);
    check("cur_init", cur, 12'h000);
    // Table of laser register writes with range, current and readback.
    foreach (rows[i])
    begin
      host.wr(rows[i].a, rows[i].d);
      repeat (3) @(posedge mclk);
      check("range", rng, {10'h000, rows[i].rng});
      check("current", cur, {4'h0, rows[i].cur});
      host.rd(rows[i].a, rd_v);
      check("readback", rd_v, {4'h0, rows[i].d});
    end
    host.restore();
    host.wr(7'h1C, 8'h10);
    host.wr(7'h1D, 8'hEF);
    repeat (3) @(posedge mclk);
    check("cur_set", cur, 12'h010);
    count_drive(100);
    check("pulse", cnt, 12'h028);
    host.wr(7'h1A, 8'h4E);
    repeat (3) @(posedge mclk);
    count_drive(100);
    check("cal_cw", cnt, 12'h064);
    host.wr(7'h1A, 8'h40);
    host.wr(7'h1F, 8'h40);
    repeat (3) @(posedge mclk);
    count_drive(40);
    check("bad_drv", cnt, 12'h000);
    check("bad_cur", cur, 12'h000);
    host.wr(7'h1F, 8'h80);
    // Motion at the reset resolution code one, which doubles every step.
    frame(8'h05, 8'hFE);
    repeat (2) @(posedge mclk);
    check("mot_on", mot_n, 12'h000);
    host.rd(7'h03, rd_v);
    check("dx_lo", rd_v, 12'h00A);
    host.rd(7'h04, rd_v);
    check("dy_lo", rd_v, 12'h0FC);
    host.rd(7'h05, rd_v);
    check("xy_hi", rd_v, 12'h0F0);
    repeat (2) @(posedge mclk);
    check("mot_off", mot_n, 12'h001);
    // Highest resolution; an out-of-range code must be ignored.
    host.wr(7'h0D, 8'h04);
    host.wr(7'h0D, 8'h05);
    host.rd(7'h0D, rd_v);
    check("res", rd_v, 12'h004);
    repeat (4) frame(8'h7F, 8'h00);
    host.rd(7'h03, rd_v);
    check("sat_lo", rd_v, 12'h0FF);
    host.rd(7'h05, rd_v);
    check("sat_hi", rd_v, 12'h007);
    host.rd(7'h7E, rd_v);
    check("unmapped", rd_v, 12'h000);
    check("oe_idle", miso_oe, 12'h000);
    // Base resolution: one frame step is counted exactly once.
    host.wr(7'h0D, 8'h00);
    frame(8'hFD, 8'h00);
    host.rd(7'h03, rd_v);
    check("res0_lo", rd_v, 12'h0FD);
    host.rd(7'h05, rd_v);
    check("res0_hi", rd_v, 12'h00F);
    // A one-cycle fault must latch the supply off.
    @(posedge mclk);
    fault <= 1'b1;
    @(posedge mclk);
    fault <= 1'b0;
    repeat (3) @(posedge mclk);
    count_drive(20);
    check("flt_sup", sup_n, 12'h001);
    check("flt_drv", cnt, 12'h000);
    host.rd(7'h02, rd_v);
    check("status", rd_v, 12'h001);
    // Mid-run reset clears the fault latch; the controller then restores the pair.
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    check("sup_rst2", sup_n, 12'h000);
    check("rng_rst2", rng, 12'h000);
    rst_b <= 1'b1;
    host.restore();
    repeat (3) @(posedge mclk);
    check("rng_rest", rng, 12'h001);
    count_drive(100);
    check("pulse2", cnt, 12'h028);
    // A low clock enable freezes the pulse timebase, so the drive holds its level.
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    rd_v = {7'h00, drv};
    count_drive(20);
    check("ce_hold", cnt, rd_v[0] ? 12'h014 : 12'h000);
    ce <= 1'b1;
    end_sim();
  end
endmodule : tb_top
